// ==== fault_status_pkg.sv ====
/*
  Constants and carrier types for the fault status and latch-off block.
  Assumes a PMBus framing engine on the link clock that hands over decoded
  command codes. The engine also takes back the answer bytes.
*/
package fault_status_pkg;

  // Command codes seen on the decoded link port
  localparam logic [7:0] CMD_OPERATION     = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
  localparam logic [7:0] CMD_SUMMARY_LOW   = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_FULL  = 8'h79;
  localparam logic [7:0] CMD_VOUT_FLAGS    = 8'h7a;
  localparam logic [7:0] CMD_INPUT_FLAGS   = 8'h7c;
  localparam logic [7:0] CMD_TEMP_FLAGS    = 8'h7d;

  // Summary word bit positions
  localparam int SW_VOUT      = 15;
  localparam int SW_IOUT      = 14;
  localparam int SW_INPUT     = 13;
  localparam int SW_MFR       = 12;
  localparam int SW_PNG       = 11;
  localparam int SW_BUSY      = 7;
  localparam int SW_OFF       = 6;
  localparam int SW_VOUT_OV   = 5;
  localparam int SW_IOUT_OC   = 4;
  localparam int SW_VIN_UV    = 3;
  localparam int SW_TEMP      = 2;
  localparam int SW_CML       = 1;
  localparam int SW_HIGH_BYTE = 0;

  // Detailed flag positions
  localparam int VO_OV_FAULT  = 7;
  localparam int VO_UV_FAULT  = 4;
  localparam int IN_UV_FAULT  = 4;
  localparam int OPERATION_ON = 7;

  // Implemented bits of each detailed register
  localparam logic [7:0] VOUT_MASK  = 8'hfc;
  localparam logic [7:0] INPUT_MASK = 8'hf8;
  localparam logic [7:0] TEMP_MASK  = 8'hf0;

  // Values after reset
  localparam logic [7:0]  FLAGS_RESET     = 8'h00;
  localparam logic [7:0]  OPERATION_RESET = 8'h00;
  localparam logic [15:0] RSP_RESET       = 16'h0000;

  // Fault and warning events, one-cycle or level, from the supervisors
  typedef struct packed {
    logic [7:0] vout;   // ov_fault ov_warn uv_warn uv_fault max_warn ton_max - -
    logic [7:0] vin;    // ov_fault ov_warn uv_warn uv_fault off - - -
    logic [7:0] temp;   // ot_fault ot_warn ut_warn ut_fault - - - -
  } fault_events_t;

  // Decoded command held on the link side during a crossing
  typedef struct packed {
    logic       write;
    logic [7:0] code;
    logic [7:0] data;
  } link_cmd_t;

endpackage : fault_status_pkg

// ==== fault_status_top.sv ====
/*
  Fault latch, alert line and status reporting for one channel page.
  Link side runs on i_link_clk and exchanges commands by toggle handshake.
  Pins (control, input sense) are asynchronous; supervisors share i_sys_clk.
*/
module fault_status_top
  import fault_status_pkg::*;
(
  // System clock and reset
  input  wire logic          i_sys_clk,
  input  wire logic          i_sys_rst,
  // Link clock domain, decoded command port
  input  wire logic          i_link_clk,
  input  wire logic          i_link_rst,
  input  wire logic          i_link_cmd_valid,
  input  wire link_cmd_t     i_link_cmd,
  output logic               o_link_rd_valid,
  output logic [15:0]        o_link_rd_data,
  // Asynchronous pins
  input  wire logic          i_control_pin,
  input  wire logic          i_input_sense_pin,
  // Supervisors and sequencer on the system clock
  input  wire fault_events_t i_events,
  input  wire logic          i_fault_shutdown,
  input  wire logic          i_mfr_fault,
  input  wire logic          i_cml_fault,
  input  wire logic          i_power_good_out_en,
  input  wire logic          i_power_good_out,
  // Channel and alert outputs
  output logic               o_chan_run,
  output logic               o_alert_line_n_out,
  output logic               o_alert_line_n_oe
);

  // Sticky update: a set in the clearing cycle wins
  function automatic logic [7:0] sticky8(input logic [7:0] cur, input logic [7:0] ev,
                                         input logic clr, input logic [7:0] mask);
    sticky8 = ((clr ? 8'h00 : cur) | ev) & mask;
  endfunction

  // Link domain state
  link_cmd_t   lcmd_reg;
  logic        req_tgl_reg;
  logic        busy_tgl_reg;
  logic        ack_s1_reg;
  logic        ack_s2_reg;
  logic        ack_s3_reg;
  logic        rd_valid_reg;
  logic [15:0] rd_data_reg;

  // System domain state
  logic        req_s1_reg;
  logic        req_s2_reg;
  logic        req_s3_reg;
  logic        bsy_s1_reg;
  logic        bsy_s2_reg;
  logic        bsy_s3_reg;
  logic        ctl_s1_reg;
  logic        ctl_s2_reg;
  logic        ctl_s3_reg;
  logic        sns_s1_reg;
  logic        sns_s2_reg;
  logic        sns_s3_reg;
  logic        ack_tgl_reg;
  logic [15:0] rsp_reg;
  logic        latch_off_reg;
  logic [7:0]  operation_reg;
  logic [7:0]  vout_reg;
  logic [7:0]  input_reg;
  logic [7:0]  temp_reg;
  logic        busy_reg;
  logic        chan_run_reg;
  logic        alert_reg;

  // Link side decode
  wire         link_pending = req_tgl_reg ^ ack_s2_reg;
  wire         link_accept  = i_link_cmd_valid & ~link_pending;
  wire         link_overrun = i_link_cmd_valid & link_pending;
  wire         link_done    = ack_s2_reg ^ ack_s3_reg;
  wire         link_rd_done = link_done & ~lcmd_reg.write;

  // Ack toggle back into the link clock
  always_ff @(posedge i_link_clk) begin
    if (i_link_rst) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
    end
  end

  // Capture command and flip request
  // Limitation: one command in flight; a refused one is not queued
  always_ff @(posedge i_link_clk) begin
    if (i_link_rst) begin
      lcmd_reg     <= '0;
      req_tgl_reg  <= 1'b0;
      busy_tgl_reg <= 1'b0;
    end else begin
      if (link_accept) begin
        lcmd_reg    <= i_link_cmd;
        req_tgl_reg <= ~req_tgl_reg;
      end
      if (link_overrun) begin
        busy_tgl_reg <= ~busy_tgl_reg; // Command while earlier one in flight
      end
    end
  end

  // Answer on ack edge; data moves only on reads, so it stands to the next answer
  always_ff @(posedge i_link_clk) begin
    if (i_link_rst) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= RSP_RESET;
    end else begin
      rd_valid_reg <= link_rd_done;
      if (link_rd_done) begin
        rd_data_reg <= rsp_reg; // Stable: system side waits for next request
      end
    end
  end

  assign o_link_rd_valid = rd_valid_reg;
  assign o_link_rd_data  = rd_data_reg;

  // Event edges and the bias level after synchronisers
  wire sys_req      = req_s2_reg ^ req_s3_reg;
  wire sys_busy_ev  = bsy_s2_reg ^ bsy_s3_reg;
  wire ctl_toggle   = ctl_s2_reg ^ ctl_s3_reg;
  wire bias_restore = sns_s2_reg & ~sns_s3_reg;
  wire bias_present = sns_s2_reg;

  // Command decode; lcmd_reg is held still while the request is pending
  wire is_write     = sys_req & lcmd_reg.write;
  wire wr_operation = is_write & (lcmd_reg.code == CMD_OPERATION);
  wire wr_onoff     = is_write & (lcmd_reg.code == CMD_ON_OFF_CONFIG);
  wire wr_clear     = sys_req & (lcmd_reg.code == CMD_CLEAR_FAULTS);
  wire turn_on_cmd  = wr_operation & lcmd_reg.data[OPERATION_ON];

  // Reset actions for the off latch
  wire latch_release = ctl_toggle | wr_operation | wr_onoff | bias_restore;

  // Sticky clear sources; latch is untouched by clear faults
  wire status_clear = wr_clear | turn_on_cmd;

  // Output permitted only when commanded, unlatched and biased
  wire out_permitted = operation_reg[OPERATION_ON] & ~latch_off_reg & bias_present;

  // Summary word formed from detailed flags and level inputs
  wire power_not_good = i_power_good_out_en & ~i_power_good_out;
  wire vout_any       = |vout_reg;
  wire input_any      = |input_reg;
  wire temp_any       = |temp_reg;
  wire other_fault    = (|(vout_reg & ~(8'h01 << VO_OV_FAULT)))
                      | (|(input_reg & ~(8'h01 << IN_UV_FAULT)))
                      | i_mfr_fault | power_not_good;
  // Assembled live, so a clear shows in the very next answer
  logic [15:0] summary;
  always_comb begin
    summary               = 16'h0000; // Unsupported bits stay zero
    summary[SW_VOUT]      = vout_any;
    summary[SW_INPUT]     = input_any;
    summary[SW_MFR]       = i_mfr_fault;
    summary[SW_PNG]       = power_not_good;
    summary[SW_BUSY]      = busy_reg;
    summary[SW_OFF]       = ~out_permitted;
    summary[SW_VOUT_OV]   = vout_reg[VO_OV_FAULT];
    summary[SW_VIN_UV]    = input_reg[IN_UV_FAULT];
    summary[SW_TEMP]      = temp_any;
    summary[SW_CML]       = i_cml_fault;
    summary[SW_HIGH_BYTE] = other_fault;
  end

  // Read answer selection
  logic [15:0] rsp_next;
  always_comb begin
    unique case (lcmd_reg.code)
      CMD_SUMMARY_LOW:  rsp_next = {8'h00, summary[7:0]}; // Same bits as word
      CMD_SUMMARY_FULL: rsp_next = summary;
      CMD_VOUT_FLAGS:   rsp_next = {8'h00, vout_reg};
      CMD_INPUT_FLAGS:  rsp_next = {8'h00, input_reg};
      CMD_TEMP_FLAGS:   rsp_next = {8'h00, temp_reg};
      CMD_OPERATION:    rsp_next = {8'h00, operation_reg};
      default:          rsp_next = RSP_RESET;
    endcase
  end

  // Next values of the sticky flags; masks hold unsupported bits at zero
  wire [7:0] vout_next  = sticky8(vout_reg, i_events.vout, status_clear, VOUT_MASK);
  wire [7:0] input_next = sticky8(input_reg, i_events.vin, status_clear, INPUT_MASK);
  wire [7:0] temp_next  = sticky8(temp_reg, i_events.temp, status_clear, TEMP_MASK);
  wire       busy_next  = (busy_reg & ~status_clear) | sys_busy_ev;

  // Alert follows recorded flags and level faults, so a clear releases it
  wire alert_next = (|vout_next) | (|input_next) | (|temp_next) | busy_next
                  | i_mfr_fault | i_cml_fault;

  // Link request toggle into the system clock
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
    end
  end

  // Link busy toggle into the system clock
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      bsy_s1_reg <= 1'b0;
      bsy_s2_reg <= 1'b0;
      bsy_s3_reg <= 1'b0;
    end else begin
      bsy_s1_reg <= busy_tgl_reg;
      bsy_s2_reg <= bsy_s1_reg;
      bsy_s3_reg <= bsy_s2_reg;
    end
  end

  // Control pin synchroniser and edge stage
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctl_s1_reg <= 1'b0;
      ctl_s2_reg <= 1'b0;
      ctl_s3_reg <= 1'b0;
    end else begin
      ctl_s1_reg <= i_control_pin;
      ctl_s2_reg <= ctl_s1_reg;
      ctl_s3_reg <= ctl_s2_reg;
    end
  end

  // Bias sense pin; reset low, so a biased pin looks like a harmless reapply
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sns_s1_reg <= 1'b0;
      sns_s2_reg <= 1'b0;
      sns_s3_reg <= 1'b0;
    end else begin
      sns_s1_reg <= i_input_sense_pin;
      sns_s2_reg <= sns_s1_reg;
      sns_s3_reg <= sns_s2_reg;
    end
  end

  // Command handling and answer handshake
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ack_tgl_reg <= 1'b0;
      rsp_reg     <= RSP_RESET;
    end else if (sys_req) begin
      ack_tgl_reg <= ~ack_tgl_reg;
      rsp_reg     <= rsp_next;
    end
  end

  // Operation byte; bit 7 is the on command that gates the output
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      operation_reg <= OPERATION_RESET;
    end else if (wr_operation) begin
      operation_reg <= lcmd_reg.data;
    end
  end

  // Off latch: a new fault beats a release in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      latch_off_reg <= 1'b0;
    end else if (i_fault_shutdown) begin
      latch_off_reg <= 1'b1;
    end else if (latch_release) begin
      latch_off_reg <= 1'b0;
    end
  end

  // Sticky flags
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      vout_reg  <= FLAGS_RESET;
      input_reg <= FLAGS_RESET;
      temp_reg  <= FLAGS_RESET;
      busy_reg  <= 1'b0;
    end else begin
      vout_reg  <= vout_next;
      input_reg <= input_next;
      temp_reg  <= temp_next;
      busy_reg  <= busy_next;
    end
  end

  // Alert enable; unsupported event bits are masked and never pull the line
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= alert_next;
    end
  end

  // Registered pin outputs; the line is open drain, driven only when low
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      chan_run_reg <= 1'b0;
    end else begin
      chan_run_reg <= out_permitted & ~i_fault_shutdown;
    end
  end

  assign o_chan_run         = chan_run_reg;
  assign o_alert_line_n_out = 1'b0;
  assign o_alert_line_n_oe  = alert_reg;

endmodule // fault_status_top

// ==== fault_status_top_bench.sv ====
/*
  Self-checking bench for fault_status_top with a host model on the link.
  Assumes the checker is bound in; link clock free-running at 80 ns.
*/
module fault_status_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fault_status_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, link_clk = 1'b0, link_rst = 1'b1;
  logic cmd_valid, rd_valid, ctrl = 1'b0, bias = 1'b1, shut = 1'b0;
  logic mfr = 1'b0, cml = 1'b0, pg_en = 1'b0, pg = 1'b0, run, al_out, al_oe;
  link_cmd_t cmd;
  logic [15:0] rd_data;
  fault_events_t events = '0;
  int error_cnt = 0;
  int check_count = 0;
  // Link edges fall on 40k ns, never on a system rising edge
  always #4 sys_clk = ~sys_clk;
  always #40 link_clk = ~link_clk;
  fault_status_top u_dut (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_link_clk(link_clk), .i_link_rst(link_rst),
    .i_link_cmd_valid(cmd_valid), .i_link_cmd(cmd), .o_link_rd_valid(rd_valid),
    .o_link_rd_data(rd_data), .i_control_pin(ctrl), .i_input_sense_pin(bias),
    .i_events(events), .i_fault_shutdown(shut), .i_mfr_fault(mfr), .i_cml_fault(cml),
    .i_power_good_out_en(pg_en), .i_power_good_out(pg), .o_chan_run(run),
    .o_alert_line_n_out(al_out), .o_alert_line_n_oe(al_oe));
  link_host_model u_host (.i_link_clk(link_clk), .o_valid(cmd_valid), .o_cmd(cmd),
    .i_rd_valid(rd_valid), .i_rd_data(rd_data));
  task automatic give_verdict;
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // Link access; a lost answer ends the run
  task automatic acc(input logic w, input logic [7:0] c, input logic [7:0] d,
                     input logic [15:0] exp);
    logic [15:0] r;
    logic        ok;
    u_host.xfer(w, c, d, r, ok);
    if (!ok) begin
      error_cnt++;
      give_verdict();
    end else if (!w) chk(r, exp);
  endtask
  task automatic ev(input fault_events_t e);
    @(posedge sys_clk) events <= e;
    @(posedge sys_clk) events <= '0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic t_flags;
    acc(1, CMD_OPERATION, 8'h80, 0);
    chk({15'h0, run}, 16'h0001);
    acc(0, CMD_SUMMARY_FULL, 0, 16'h0000);
    ev('{vout: 8'h80, vin: 8'h00, temp: 8'h00});
    chk({15'h0, al_oe}, 16'h0001);
    chk({15'h0, al_out}, 16'h0000);
    acc(0, CMD_VOUT_FLAGS, 0, 16'h0080);
    acc(0, CMD_SUMMARY_FULL, 0, 16'h8020);
    acc(0, CMD_SUMMARY_LOW, 0, 16'h0020);
    acc(1, CMD_CLEAR_FAULTS, 0, 0);
    acc(0, CMD_SUMMARY_FULL, 0, 16'h0000);
    chk({15'h0, al_oe}, 16'h0000);
    ev('1);
    acc(0, CMD_VOUT_FLAGS, 0, 16'h00fc);
    acc(0, CMD_INPUT_FLAGS, 0, 16'h00f8);
    acc(0, CMD_TEMP_FLAGS, 0, 16'h00f0);
    acc(0, CMD_SUMMARY_FULL, 0, 16'ha02d);
    acc(0, CMD_SUMMARY_LOW, 0, 16'h002d);
    acc(1, CMD_CLEAR_FAULTS, 0, 0);
  endtask
  // Shut down, then release by control pin toggle, CMD_ON_OFF_CONFIG write and bias reapply in turn
  task automatic t_latch;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk) shut <= 1'b1;
      @(posedge sys_clk) shut <= 1'b0;
      acc(1, CMD_CLEAR_FAULTS, 0, 0);
      chk({15'h0, run}, 16'h0000);
      acc(0, CMD_SUMMARY_FULL, 0, 16'h0040);
      if (i == 0) @(posedge sys_clk) ctrl <= ~ctrl;
      if (i == 1) acc(1, CMD_ON_OFF_CONFIG, 0, 0);
      if (i == 2) @(posedge sys_clk) bias <= 1'b0;
      repeat (8) @(posedge sys_clk);
      bias <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk({15'h0, run}, 16'h0001);
    end
  endtask
  // Level inputs {pg_en, pg, mfr, cml} and the summary each gives
  task automatic t_levels;
    logic [3:0]  lv [4] = '{4'h8, 4'hc, 4'h2, 4'h1};
    logic [15:0] ex [4] = '{16'h0801, 16'h0000, 16'h1001, 16'h0002};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) {pg_en, pg, mfr, cml} <= lv[i];
      repeat (4) @(posedge sys_clk);
      acc(0, CMD_SUMMARY_FULL, 0, ex[i]);
    end
    chk({15'h0, al_oe}, 16'h0001);
    @(posedge sys_clk) {pg_en, pg, mfr, cml} <= 4'h0;
  endtask
  // Second command while the first is still crossing
  task automatic t_busy;
    u_host.send(1'b1, CMD_OPERATION, 8'h80);
    u_host.send(1'b1, CMD_ON_OFF_CONFIG, 8'h00);
    repeat (12) @(posedge link_clk);
    acc(0, CMD_SUMMARY_FULL, 0, 16'h0080);
    acc(1, CMD_CLEAR_FAULTS, 0, 0);
    acc(0, CMD_SUMMARY_FULL, 0, 16'h0000);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge link_clk);
    link_rst <= 1'b0;
    repeat (4) @(posedge link_clk);
    chk({15'h0, run}, 16'h0000);
    acc(0, CMD_SUMMARY_FULL, 0, 16'h0040);
    t_flags();
    t_latch();
    t_levels();
    t_busy();
    give_verdict();
  end
endmodule // fault_status_top_bench

// ==== fault_status_top_chk.sv ====
/*
  Port checker for the fault status block: latch, alert and link answers.
  Assumes it is bound into fault_status_top; both resets are synchronous.
*/
module fault_status_top_chk
  import fault_status_pkg::*;
(
  // Clocks and resets
  input wire logic          i_sys_clk,
  input wire logic          i_sys_rst,
  input wire logic          i_link_clk,
  input wire logic          i_link_rst,
  // Link command and answer
  input wire logic          i_link_cmd_valid,
  input wire link_cmd_t     i_link_cmd,
  input wire logic          o_link_rd_valid,
  input wire logic [15:0]   o_link_rd_data,
  // Fault side
  input wire fault_events_t i_events,
  input wire logic          i_fault_shutdown,
  input wire logic          o_chan_run,
  input wire logic          o_alert_line_n_oe
);
  // Last command code, so an answer can be judged by its register
  logic [7:0] code_reg;
  always_ff @(posedge i_link_clk) begin
    if (i_link_rst) code_reg <= 8'h00;
    else if (i_link_cmd_valid) code_reg <= i_link_cmd.code;
  end
  // Masked events only; unsupported bits never raise the alert
  logic ev_any;
  logic rd_cmd;
  logic rv;
  assign ev_any = |{i_events.vout & VOUT_MASK, i_events.vin & INPUT_MASK,
                    i_events.temp & TEMP_MASK};
  assign rd_cmd = i_link_cmd_valid && !i_link_cmd.write;
  assign rv = o_link_rd_valid;
  property p_latch;
    @(posedge i_sys_clk) disable iff (i_sys_rst) i_fault_shutdown |=> !o_chan_run [*2];
  endproperty
  a_latch: assert property (p_latch) else $error("channel ran after shutdown");
  property p_rise;
    @(posedge i_sys_clk) disable iff (i_sys_rst) $rose(o_chan_run) |-> !$past(i_fault_shutdown);
  endproperty
  a_rise: assert property (p_rise) else $error("release beat shutdown");
  property p_alert;
    @(posedge i_sys_clk) disable iff (i_sys_rst) ev_any |=> o_alert_line_n_oe;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not driven on event");
  property p_ans;
    @(posedge i_link_clk) disable iff (i_link_rst) rd_cmd |=> !rv [*3] ##[1:3] rv ##1 !rv;
  endproperty
  a_ans: assert property (p_ans) else $error("read answer timing wrong");
  property p_byte;
    @(posedge i_link_clk) disable iff (i_link_rst)
      rv && code_reg == CMD_SUMMARY_LOW |-> o_link_rd_data[15:8] == 8'h00;
  endproperty
  a_byte: assert property (p_byte) else $error("byte summary high byte set");
  property p_word0;
    @(posedge i_link_clk) disable iff (i_link_rst)
      rv && code_reg == CMD_SUMMARY_FULL |-> (o_link_rd_data & 16'h4710) == 16'h0000;
  endproperty
  a_word0: assert property (p_word0) else $error("unsupported summary bit set");
  property p_hb;
    @(posedge i_link_clk) disable iff (i_link_rst)
      rv && code_reg == CMD_SUMMARY_FULL && o_link_rd_data[11] |-> o_link_rd_data[0];
  endproperty
  a_hb: assert property (p_hb) else $error("power not good without bit 0");
  property p_temp;
    @(posedge i_link_clk) disable iff (i_link_rst)
      rv && code_reg == CMD_TEMP_FLAGS |-> o_link_rd_data[3:0] == 4'h0;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature low nibble set");
endmodule // fault_status_top_chk

bind fault_status_top fault_status_top_chk u_chk (
  .i_sys_clk, .i_sys_rst, .i_link_clk, .i_link_rst, .i_link_cmd_valid, .i_link_cmd,
  .o_link_rd_valid, .o_link_rd_data, .i_events, .i_fault_shutdown, .o_chan_run,
  .o_alert_line_n_oe
);

// ==== link_host_model.sv ====
/*
  Host model on the decoded link port: sends commands, collects answers.
  Assumes the bench calls its tasks one at a time on the link clock.
*/
module link_host_model
  import fault_status_pkg::*;
(
  // Link clock
  input  wire logic        i_link_clk,
  // Command towards the block
  output logic             o_valid,
  output link_cmd_t        o_cmd,
  // Answer from the block
  input  wire logic        i_rd_valid,
  input  wire logic [15:0] i_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    o_cmd = '0;
  end
  // One pulse; released fields show the inverse so stale data is never trusted
  task automatic send(input logic w, input logic [7:0] c, input logic [7:0] d);
    @(posedge i_link_clk);
    o_valid <= 1'b1;
    o_cmd <= link_cmd_t'({w, c, d});
    @(posedge i_link_clk);
    o_valid <= 1'b0;
    o_cmd <= link_cmd_t'(~{w, c, d});
  endtask
  // Reads wait for the answer; writes get a fixed settling gap
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
                      output logic [15:0] r, output logic ok);
    ok = w;
    r = 16'h0000;
    send(w, c, d);
    for (int n = 0; n < 12 && !(ok && !w); n++) begin
      @(posedge i_link_clk);
      if (i_rd_valid && !w) begin
        ok = 1'b1;
        r = i_rd_data;
      end
    end
  endtask
endmodule // link_host_model
